// ==== rtl/sdl_pkg.sv ====
// Behaviour
// RL1 - frame select low opens a write; bits accepted while it stays low
// RL2 - serial data sampled on each falling edge of the serial clock
// RL3 - shift register is sixteen bits wide; one frame is sixteen bits
// RL4 - after the sixteenth falling edge the word updates code and mode
// RL5 - frame select rising early aborts; code and mode stay unchanged
// RL6 - host keeps the serial clock at or below the maximum rate; the bench host drives it with 6 ns periods, far above SCLK_MAX_MHZ
// RL7 - falling edges while frame select is high shift nothing
// RL8 - two leading bits pick mode: normal, 1k, 100k, high impedance
// RL9 - twelve bits after the mode bits form the code; last two ignored
// RL10 - reset clears code to zero until a complete frame arrives
// RL11 - frame select must return high before the next frame may start
// RL12 - bits arrive most significant first
package sdl_pkg;
  localparam int FRAME_BITS = 16;
  localparam int CODE_BITS = 12;
  localparam int MODE_HI_POS = 15;
  localparam int MODE_LO_POS = 14;
  localparam int CODE_LSB_POS = 2;
  localparam logic [4:0] FRAME_LAST = 5'h10;
  localparam logic [11:0] CODE_RESET = 12'h000;
  localparam int SCLK_MAX_MHZ = 30;
  localparam int REF_CLK_MHZ = 200;

  typedef enum logic [1:0] {
    SDL_MODE_NORMAL = 2'b00,
    SDL_MODE_PD_1K = 2'b01,
    SDL_MODE_PD_100K = 2'b10,
    SDL_MODE_HIZ = 2'b11
  } sdl_mode_t;

  localparam sdl_mode_t MODE_RESET = SDL_MODE_NORMAL;
endpackage : sdl_pkg

// ==== rtl/sdl_sync2.sv ====
`timescale 1ns/1ps
`default_nettype none
module sdl_sync2 (
  input wire logic clk,
  input wire logic rst,
  input wire logic rst_val,
  input wire logic d,
  output logic q
);
  logic s1_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_r <= 1'b0;
      q <= 1'b0;
    end else begin
      s1_r <= d;
      q <= s1_r;
    end
  end
  // rst_val unused for flop value; constant reset keeps idle low
  logic unused_ok;
  assign unused_ok = rst_val;
endmodule : sdl_sync2
`default_nettype wire

// ==== rtl/sdl_shifter.sv ====
`timescale 1ns/1ps
`default_nettype none
// link-side shifter on the serial clock's falling edge; frame select async clears count and done flag, not the word
module sdl_shifter
  import sdl_pkg::*;
(
  input wire logic sclk,
  input wire logic frame_sel_n,
  input wire logic serial_data_in,
  output logic [15:0] word_r,
  output logic frame_done_r
);
  logic [4:0] cnt_r;
  // RL5 frame abort clears
  always_ff @(negedge sclk or posedge frame_sel_n) begin
    if (frame_sel_n) begin
      cnt_r <= 5'h00;
      frame_done_r <= 1'b0;
    end else if (cnt_r != FRAME_LAST) begin
      cnt_r <= cnt_r + 5'h01;
      // RL4 sixteenth edge
      frame_done_r <= (cnt_r == FRAME_LAST - 5'h01);
    end
  end
  // data register not cleared so done word survives until read
  always_ff @(negedge sclk) begin
    // RL7 ignore while high
    if (!frame_sel_n && cnt_r != FRAME_LAST) begin
      // RL2 RL12 falling edge, msb first
      word_r <= {word_r[14:0], serial_data_in};
    end
  end
  ////////////////////////////////////////////////////////////
  // RL3 word frozen after frame
  property p_word_frozen;
    @(negedge sclk) disable iff (frame_sel_n) cnt_r == FRAME_LAST |=> $stable(word_r);
  endproperty
  a_word_frozen: assert property (p_word_frozen) else $error("word shifted after frame end"); // RL3
endmodule : sdl_shifter
`default_nettype wire

// ==== rtl/sdl_loader.sv ====
`timescale 1ns/1ps
`default_nettype none
module sdl_loader
  import sdl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic frame_sel_n,
  input wire logic serial_data_in,
  output logic [11:0] dac_code,
  output var sdl_pkg::sdl_mode_t mode,
  output logic load_pulse
);
  import sdl_pkg::*;

  typedef struct packed {
    logic tgl_d;
    logic pend;
    logic [11:0] code;
    sdl_mode_t mode;
    logic load;
  } sdl_state_t;

  logic [15:0] word_w;
  logic tgl_w;
  logic tgl_s;
  sdl_state_t st_r;
  sdl_state_t st_nxt;

  ////////////////////////////////////////////////////////////
  // RL1 RL3 frame capture
  sdl_shifter u_shift (
    .sclk(sclk),
    .frame_sel_n(frame_sel_n),
    .serial_data_in(serial_data_in),
    .word_r(word_w),
    .frame_done_r(tgl_w)
  );

  sdl_sync2 u_sync (
    .clk(ref_clk),
    .rst(rst),
    .rst_val(1'b0),
    .d(tgl_w),
    .q(tgl_s)
  );

  ////////////////////////////////////////////////////////////
  // word is stable: shifter freezes after the sixteenth edge
  always_comb begin
    st_nxt = st_r;
    st_nxt.load = 1'b0;
    st_nxt.tgl_d = tgl_s;
    // level done flag; rising edge only, held low by frame select gap
    if (tgl_s && !st_r.tgl_d) begin
      // RL8 mode bits
      st_nxt.mode = sdl_mode_t'({word_w[MODE_HI_POS], word_w[MODE_LO_POS]});
      // RL9 twelve code bits
      st_nxt.code = word_w[CODE_LSB_POS +: CODE_BITS];
      st_nxt.load = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    // RL10 reset clears code
    if (rst) begin
      st_r <= '{tgl_d: 1'b0, pend: 1'b0, code: CODE_RESET, mode: MODE_RESET, load: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dac_code = st_r.code;
  assign mode = st_r.mode;
  assign load_pulse = st_r.load;

  ////////////////////////////////////////////////////////////
  property p_code_hold;
    @(posedge ref_clk) disable iff (rst) !st_r.load |=> $stable(st_r.code) || st_r.load;
  endproperty
  a_code_hold: assert property (p_code_hold) else $error("code changed without load"); // RL5
  property p_load_one;
    @(posedge ref_clk) disable iff (rst) st_r.load |=> !st_r.load;
  endproperty
  a_load_one: assert property (p_load_one) else $error("load longer than a cycle"); // RL4
  property p_reset_zero;
    @(posedge ref_clk) $fell(rst) |-> dac_code == CODE_RESET;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("code not cleared"); // RL10
  sequence s_done_rise;
    tgl_s && !st_r.tgl_d;
  endsequence
  property p_load_follows;
    @(posedge ref_clk) disable iff (rst) s_done_rise |=> st_r.load;
  endproperty
  a_load_follows: assert property (p_load_follows) else $error("frame end gave no load"); // RL4
  property p_load_cause;
    @(posedge ref_clk) disable iff (rst) st_r.load |-> $past(tgl_s) && !$past(st_r.tgl_d);
  endproperty
  a_load_cause: assert property (p_load_cause) else $error("load without frame end"); // RL5
  property p_mode_hold;
    @(posedge ref_clk) disable iff (rst) !st_r.load |=> $stable(st_r.mode) || st_r.load;
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed without load"); // RL8
endmodule : sdl_loader
`default_nettype wire

// ==== verification/sdl_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module sdl_host_model (
  output logic sclk,
  output logic frame_sel_n,
  output logic serial_data_in
);
  initial begin
    sclk = 1'b1;
    frame_sel_n = 1'b1;
    serial_data_in = 1'b0;
  end
  task automatic send(input logic [15:0] w, input int n, input int extra);
    #($urandom_range(6, 1));
    frame_sel_n = 1'b0;
    #10;
    // fixed half periods of the bench link clock
    for (int i = 0; i < n + ((n == 16) ? extra : 0); i++) begin
      serial_data_in = (i < n) ? w[15-i] : ~serial_data_in;
      #3 sclk = 1'b0;
      #3 sclk = 1'b1;
    end
    #3 frame_sel_n = 1'b1;
    // released line shows no stale bit
    serial_data_in = ~serial_data_in;
    #13;
    repeat (extra) begin
      #3 sclk = 1'b0;
      #3 sclk = 1'b1;
    end
    #40;
  endtask : send
endmodule : sdl_host_model
`default_nettype wire

// ==== verification/test_serial_dac_word_loader.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_serial_dac_word_loader;
  import sdl_pkg::*;
  logic ref_clk, rst, sclk, frame_sel_n, serial_data_in, load_pulse, seen;
  logic [11:0] dac_code, exp_code;
  logic [1:0] exp_mode;
  logic [15:0] w;
  sdl_mode_t mode;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  sdl_host_model HOST (.sclk(sclk), .frame_sel_n(frame_sel_n), .serial_data_in(serial_data_in));
  sdl_loader DUT (.ref_clk(ref_clk), .rst(rst), .sclk(sclk), .frame_sel_n(frame_sel_n),
    .serial_data_in(serial_data_in), .dac_code(dac_code), .mode(mode), .load_pulse(load_pulse));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [11:0] e, input logic [11:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic give_verdict();
    if (mismatches == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic frame(input int n, input int extra);
    seen = 1'b0;
    fork
      HOST.send(w, n, extra);
      repeat (60) @(posedge ref_clk) seen = seen | load_pulse;
    join
    if (n == 16) begin
      exp_code = w[13:2];
      exp_mode = w[15:14];
    end
    chk("load", {11'h000, n == 16}, {11'h000, seen});
    chk("code", exp_code, dac_code);
    chk("mode", {10'h000, exp_mode}, {10'h000, mode});
  endtask : frame
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    w = 16'($urandom(50));
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chk("code", 12'h000, dac_code);
    exp_code = 12'h000;
    exp_mode = 2'b00;
    for (int i = 0; i < 24; i++) begin
      w = (i == 0) ? 16'hffff : 16'($urandom);
      w[15:14] = 2'(i + 1);
      frame((i % 3 == 2) ? $urandom_range(15, 1) : 16, i % 4);
    end
    give_verdict();
  end
endmodule : test_serial_dac_word_loader
`default_nettype wire
